// File: core/pcrb_pkg.sv
package pcrb_pkg;
  // Register addresses (serial address space)
  localparam logic [4:0] PCRB_ADDR_PROFILE_SIX = 5'h0C;
  localparam logic [4:0] PCRB_ADDR_PROFILE_SEVEN = 5'h0D;
  localparam logic [4:0] PCRB_ADDR_CONTROL_DEF = 5'h00;
  // Profile field positions
  localparam int PCRB_POW_HI = 61;
  localparam int PCRB_POW_LO = 48;
  localparam int PCRB_FTW_HI = 47;
  localparam int PCRB_FTW_LO = 0;
  localparam int PCRB_PROFILE_W = 64;
  localparam int PCRB_CTRL_W = 32;
  // Control field positions
  localparam int PCRB_CTRL_UNLOCK_BIT = 24;
  localparam int PCRB_CTRL_AUTO_SYNC_BIT = 3;
  localparam int PCRB_CTRL_HW_SYNC_BIT = 1;
  localparam logic [31:0] PCRB_CTRL_WRITE_MASK = 32'h00FCC0FF;
  localparam logic [63:0] PCRB_PROFILE_MASK = 64'h3FFFFFFFFFFFFFFF;
  // Reset values
  localparam logic [63:0] PCRB_PROFILE_RST = 64'h0000000000000000;
  localparam logic [31:0] PCRB_CTRL_RST = 32'h00000000;

  typedef struct packed {
    logic [13:0] phase_offset;
    logic [47:0] tuning_word;
  } pcrb_profile_s;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [4:0] addr;
    logic [63:0] wdata;
  } pcrb_access_s;
endpackage : pcrb_pkg

// File: core/pcrb_bank.sv
`timescale 1ns/1ps
module pcrb_bank (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Register access from serial port
  input wire pcrb_pkg::pcrb_access_s acc_i,
  output logic [63:0] rdata_o,
  // Loop and shared pin
  input wire logic pll_unlock_i,
  input wire logic sync_pin_i,
  output logic status_o,
  output logic status_oe_o,
  // Synchronization controls
  output logic sync_slave_o,
  output logic sync_advance_o,
  // Profile and control words
  output pcrb_pkg::pcrb_profile_s profile_six_o,
  output pcrb_pkg::pcrb_profile_s profile_seven_o,
  output logic [31:0] control_o
);
  import pcrb_pkg::*;

  // -------------------------------------------------------------
  // Register storage
  // -------------------------------------------------------------
  logic [63:0] prof6_r;
  logic [63:0] prof7_r;
  logic [31:0] ctrl_r;
  logic unlock_r;
  logic pin_d_r;
  logic [63:0] prof6_nxt;
  logic [63:0] prof7_nxt;
  logic [31:0] ctrl_nxt;
  logic [63:0] rdata_nxt;
  logic unlock_nxt;
  logic advance_nxt;

  // -------------------------------------------------------------
  // Address and mode decode
  // -------------------------------------------------------------
  wire sel6 = acc_i.addr == PCRB_ADDR_PROFILE_SIX;
  wire sel7 = acc_i.addr == PCRB_ADDR_PROFILE_SEVEN;
  wire selc = acc_i.addr == PCRB_ADDR_CONTROL_DEF;
  wire prof6_wr = acc_i.wr_en & sel6;
  wire prof7_wr = acc_i.wr_en & sel7;
  wire ctrl_wr = acc_i.wr_en & selc;
  wire ctrl_rd = acc_i.rd_en & selc;
  wire auto_sync = ctrl_r[PCRB_CTRL_AUTO_SYNC_BIT];
  wire hw_sync = ctrl_r[PCRB_CTRL_HW_SYNC_BIT];
  wire sync_mode = auto_sync | hw_sync;
  wire pin_rise = sync_pin_i & ~pin_d_r;
  wire [31:0] ctrl_view = {7'h00, unlock_r, ctrl_r[23:0]};

  // -------------------------------------------------------------
  // Register writes
  // -------------------------------------------------------------
  // Open profile bits are forced low whatever the host sends
  assign prof6_nxt = prof6_wr ? (acc_i.wdata & PCRB_PROFILE_MASK) : prof6_r;
  assign prof7_nxt = prof7_wr ? (acc_i.wdata & PCRB_PROFILE_MASK) : prof7_r;
  // All four bytes land at once; open and read-only bits are dropped
  assign ctrl_nxt = ctrl_wr ? (acc_i.wdata[31:0] & PCRB_CTRL_WRITE_MASK) : ctrl_r;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      prof6_r <= PCRB_PROFILE_RST;
      prof7_r <= PCRB_PROFILE_RST;
    end else begin
      prof6_r <= prof6_nxt;
      prof7_r <= prof7_nxt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ctrl_r <= PCRB_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // -------------------------------------------------------------
  // Read data and unlock flag
  // -------------------------------------------------------------
  assign rdata_nxt = sel6 ? prof6_r : sel7 ? prof7_r : selc ? {32'h00000000, ctrl_view} :
                     64'h0000000000000000;
  // Set wins over the clearing readback
  assign unlock_nxt = pll_unlock_i | (unlock_r & ~ctrl_rd);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      unlock_r <= 1'b0;
    end else begin
      unlock_r <= unlock_nxt;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdata_o <= 64'h0000000000000000;
    end else if (acc_i.rd_en) begin
      rdata_o <= rdata_nxt;
    end
  end

  // -------------------------------------------------------------
  // Shared pin and synchronization
  // -------------------------------------------------------------
  // Pin edges only count while hardware sync is enabled
  assign advance_nxt = hw_sync & pin_rise;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pin_d_r <= 1'b0;
      status_o <= 1'b0;
      status_oe_o <= 1'b0;
      sync_slave_o <= 1'b0;
      sync_advance_o <= 1'b0;
    end else begin
      pin_d_r <= sync_pin_i;
      status_oe_o <= ~sync_mode;
      status_o <= ~pll_unlock_i;
      sync_slave_o <= auto_sync;
      sync_advance_o <= advance_nxt;
    end
  end

  // -------------------------------------------------------------
  // Profile and control views
  // -------------------------------------------------------------
  assign profile_six_o = pcrb_profile_s'({prof6_r[PCRB_POW_HI:PCRB_POW_LO],
                                          prof6_r[PCRB_FTW_HI:PCRB_FTW_LO]});
  assign profile_seven_o = pcrb_profile_s'({prof7_r[PCRB_POW_HI:PCRB_POW_LO],
                                            prof7_r[PCRB_FTW_HI:PCRB_FTW_LO]});
  assign control_o = ctrl_view;

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  sequence s_loss;
    pll_unlock_i;
  endsequence

  sequence s_ctrl_read;
    ctrl_rd;
  endsequence

  sequence s_quiet_hold;
    (!ctrl_rd)[*3];
  endsequence

  sequence s_hw_edge;
    hw_sync && pin_rise;
  endsequence

  a_unlock_sets: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    s_loss |=> unlock_r)
    else $error("unlock flag not set");
  a_unlock_sticky: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    unlock_r && !ctrl_rd |=> unlock_r)
    else $error("unlock flag dropped");
  a_unlock_clear: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ctrl_rd && !pll_unlock_i |=> !unlock_r)
    else $error("flag not cleared");
  a_unlock_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    s_loss ##1 s_quiet_hold |=> unlock_r)
    else $error("flag lost before readback");
  a_clear_race: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    s_ctrl_read ##0 s_loss |=> unlock_r)
    else $error("event lost on clear");
  a_read_flag: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ctrl_rd && unlock_r |=> rdata_o[PCRB_CTRL_UNLOCK_BIT])
    else $error("set flag not reported");
  a_read_clean: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ctrl_rd && !unlock_r |=> !rdata_o[PCRB_CTRL_UNLOCK_BIT])
    else $error("clear flag reported set");
  a_pin_input: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    sync_mode |=> !status_oe_o)
    else $error("pin driven in sync mode");
  a_pin_driven: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !sync_mode |=> status_oe_o)
    else $error("pin not driven outside sync");
  a_status_lost: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    pll_unlock_i |=> !status_o)
    else $error("status shows lock while unlocked");
  a_status_ok: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !pll_unlock_i |=> status_o)
    else $error("status shows loss while locked");
  a_ctrl_ignore: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    control_o[31:25] == 7'h00)
    else $error("open control bits set");
  a_ctrl_store: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ctrl_wr |=> control_o[23:0] == ($past(acc_i.wdata[23:0]) & PCRB_CTRL_WRITE_MASK[23:0]))
    else $error("control write not stored");
  a_prof_open: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    prof6_r[PCRB_PROFILE_W-1:PCRB_POW_HI+1] == 2'h0 &&
    prof7_r[PCRB_PROFILE_W-1:PCRB_POW_HI+1] == 2'h0)
    else $error("open profile bits set");
  a_prof_pow: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    prof6_wr |=> profile_six_o.phase_offset == $past(acc_i.wdata[PCRB_POW_HI:PCRB_POW_LO]))
    else $error("phase offset misplaced");
  a_pow_seven: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    prof7_wr |=> profile_seven_o.phase_offset == $past(acc_i.wdata[PCRB_POW_HI:PCRB_POW_LO]))
    else $error("phase offset seven misplaced");
  a_prof_ftw: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    prof7_wr |=> profile_seven_o.tuning_word == $past(acc_i.wdata[PCRB_FTW_HI:PCRB_FTW_LO]))
    else $error("tuning word misplaced");
  a_ftw_six: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    prof6_wr |=> profile_six_o.tuning_word == $past(acc_i.wdata[PCRB_FTW_HI:PCRB_FTW_LO]))
    else $error("tuning word six misplaced");
  a_prof_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !prof6_wr |=> $stable(prof6_r))
    else $error("profile changed without write");
  a_hw_advance: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    s_hw_edge |=> sync_advance_o)
    else $error("no advance on edge");
  a_no_advance: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !hw_sync |=> !sync_advance_o)
    else $error("advance without hardware sync");
  a_auto_slave: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    auto_sync |=> sync_slave_o)
    else $error("slave not asserted");
  a_no_slave: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !auto_sync |=> !sync_slave_o)
    else $error("slave without auto sync");
endmodule : pcrb_bank

// File: tb/pcrb_host.sv
`timescale 1ns/1ps
module pcrb_host (
  // Clock
  input wire logic clk_sys_i,
  // Register access
  output pcrb_pkg::pcrb_access_s acc_o
);
  import pcrb_pkg::*;
  initial acc_o = '0;
  // One whole access, released after the taking edge
  task automatic xfer(input logic w, input logic [4:0] a, input logic [63:0] d);
    @(posedge clk_sys_i) #1 acc_o = '{w, !w, a, d};
    @(posedge clk_sys_i) #1 acc_o = '0;
  endtask : xfer
endmodule : pcrb_host

// File: tb/pcrb_bank_tb.sv
`timescale 1ns/1ps
module pcrb_bank_tb;
  import pcrb_pkg::*;
  logic clk_sys_i = 0, sys_rst_i = 1, pll_unlock_i = 0, sync_pin_i = 0;
  logic status, oe, slave, adv;
  logic [63:0] rdata;
  logic [31:0] ctrl;
  pcrb_access_s acc;
  pcrb_profile_s p6, p7;
  int n_errors = 0, checks_done = 0, cyc = 0, np;
  initial forever #5 clk_sys_i = ~clk_sys_i;
  pcrb_host host (.clk_sys_i(clk_sys_i), .acc_o(acc));
  pcrb_bank DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .acc_i(acc),
    .rdata_o(rdata), .pll_unlock_i(pll_unlock_i), .sync_pin_i(sync_pin_i),
    .status_o(status), .status_oe_o(oe), .sync_slave_o(slave),
    .sync_advance_o(adv), .profile_six_o(p6), .profile_seven_o(p7), .control_o(ctrl));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("Counts: %0d checks, %0d mismatches", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic t_profile;
    host.xfer(1, PCRB_ADDR_PROFILE_SIX, 64'h2ABCDEF012345678);
    host.xfer(1, PCRB_ADDR_PROFILE_SEVEN, 64'h1123445566778899);
    chk(p6.phase_offset, 64'h2ABC);
    chk(p6.tuning_word, 64'hDEF012345678);
    chk(p7, 64'h1123445566778899);
    host.xfer(0, PCRB_ADDR_PROFILE_SIX, 64'h0);
    chk(rdata, 64'h2ABCDEF012345678);
    $display("profile test done");
  endtask : t_profile
  task automatic pin_pulse;
    np = 0;
    sync_pin_i = 1;
    repeat (4) @(posedge clk_sys_i) #1 np += (adv === 1'b1);
    sync_pin_i = 0;
  endtask : pin_pulse
  task automatic t_sync;
    host.xfer(1, PCRB_ADDR_CONTROL_DEF, 64'h00000008);
    @(posedge clk_sys_i) #1 chk(oe, 64'h0);
    chk(slave, 64'h1);
    pin_pulse();
    chk(np, 64'h0);
    host.xfer(1, PCRB_ADDR_CONTROL_DEF, 64'h00FCC0FA);
    chk(ctrl, 64'h00FCC0FA);
    @(posedge clk_sys_i) #1 chk(oe, 64'h0);
    chk(slave, 64'h1);
    pin_pulse();
    chk(np, 64'h1);
    host.xfer(1, PCRB_ADDR_CONTROL_DEF, 64'h00000002);
    @(posedge clk_sys_i) #1 chk(oe, 64'h0);
    chk(slave, 64'h0);
    host.xfer(1, PCRB_ADDR_CONTROL_DEF, 64'h0);
    @(posedge clk_sys_i) #1 chk(oe, 64'h1);
    $display("sync test done");
  endtask : t_sync
  task automatic t_unlock;
    pll_unlock_i = 1;
    @(posedge clk_sys_i) #1 pll_unlock_i = 0;
    chk(status, 64'h0);
    @(posedge clk_sys_i) #1 chk(ctrl[24], 64'h1);
    chk(status, 64'h1);
    host.xfer(0, PCRB_ADDR_CONTROL_DEF, 64'h0);
    chk(rdata[24], 64'h1);
    host.xfer(0, PCRB_ADDR_CONTROL_DEF, 64'h0);
    chk(rdata[24], 64'h0);
    fork
      host.xfer(0, PCRB_ADDR_CONTROL_DEF, 64'h0);
      begin
        @(posedge clk_sys_i) #1 pll_unlock_i = 1;
        @(posedge clk_sys_i) #1 pll_unlock_i = 0;
      end
    join
    chk(rdata[24], 64'h0);
    host.xfer(0, PCRB_ADDR_CONTROL_DEF, 64'h0);
    chk(rdata[24], 64'h1);
    host.xfer(0, PCRB_ADDR_CONTROL_DEF, 64'h0);
    chk(rdata[24], 64'h0);
    $display("unlock test done");
  endtask : t_unlock
  task automatic t_reset;
    @(posedge clk_sys_i) #1 chk(ctrl, 64'h0);
    chk(p6, 64'h0);
    chk(oe, 64'h1);
    chk(status, 64'h1);
    chk(slave, 64'h0);
    chk(adv, 64'h0);
    $display("reset test done");
  endtask : t_reset
  initial begin
    repeat (8) @(posedge clk_sys_i);
    #1 sys_rst_i = 0;
    t_reset();
    t_profile();
    t_sync();
    t_unlock();
    end_sim();
  end
endmodule : pcrb_bank_tb
